/* File: hw/lwed_magic_match.sv */
/*
  Magic packet matcher: scans a received byte stream for a sync run
  followed by repeated copies of the node address.
  Assumes frameStart marks the first byte and nodeAddr byte 0 is sent first.
*/
`default_nettype none
module lwed_magic_match
  import lwed_pkg::*;
#(
  parameter int NBYTES = lwed_pkg::ADDR_BYTES,
  parameter int NSYNC  = lwed_pkg::SYNC_LEN,
  parameter int NCOPY  = lwed_pkg::ADDR_COPY
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control
  input  wire logic              enable,
  // Byte stream
  input  wire logic              byteValid,
  input  wire logic              frameStart,
  input  wire logic [7:0]        rxByte,
  input  wire logic [8*NBYTES-1:0] nodeAddr,
  // Result, held until next frame start or until enable drops
  output logic                   matched
);
  localparam int SW = $clog2(NSYNC + 1);
  localparam int BW = $clog2(NBYTES);
  localparam int CW = $clog2(NCOPY);

  typedef enum logic [2:0] {
    LWED_SYNC = 3'b001,
    LWED_ADDR = 3'b010,
    LWED_HIT  = 3'b100
  } lwed_match_e;

  lwed_match_e   state_ff, nxt_state, curState;
  logic [SW-1:0] syncCnt_ff, nxt_syncCnt, curSync;
  logic [BW-1:0] byteIdx_ff, nxt_byteIdx;
  logic [CW-1:0] copyIdx_ff, nxt_copyIdx;

  // Run length restarted by a byte: a sync byte starts a new run
  function automatic logic [SW-1:0] restartRun(input logic [7:0] b);
    return (b == SYNC_BYTE) ? SW'(1) : SW'(0);
  endfunction

  function automatic logic [7:0] addrByte(input logic [8*NBYTES-1:0] a,
                                          input logic [BW-1:0] i);
    return a[8*i +: 8];
  endfunction

  // Next state; a frame start discards any partial match
  always_comb begin
    curState    = frameStart ? LWED_SYNC : state_ff;
    curSync     = frameStart ? SW'(0) : syncCnt_ff;
    nxt_state   = curState;
    nxt_syncCnt = curSync;
    nxt_byteIdx = frameStart ? BW'(0) : byteIdx_ff;
    nxt_copyIdx = frameStart ? CW'(0) : copyIdx_ff;
    if (!enable) begin
      nxt_state   = LWED_SYNC;
      nxt_syncCnt = '0;
    end else if (byteValid) begin
      case (curState)
        LWED_SYNC: begin
          if (curSync == SW'(NSYNC) && rxByte == addrByte(nodeAddr, BW'(0))) begin
            nxt_state   = LWED_ADDR;
            nxt_byteIdx = BW'(1);
            nxt_copyIdx = '0;
          end else if (rxByte == SYNC_BYTE) begin
            nxt_syncCnt = (curSync == SW'(NSYNC)) ? curSync : curSync + 1'b1;
          end else begin
            nxt_syncCnt = '0;
          end
        end
        LWED_ADDR: begin
          if (rxByte == addrByte(nodeAddr, byteIdx_ff)) begin
            if (byteIdx_ff == BW'(NBYTES - 1)) begin
              nxt_byteIdx = '0;
              if (copyIdx_ff == CW'(NCOPY - 1)) begin
                nxt_state = LWED_HIT;
              end else begin
                nxt_copyIdx = copyIdx_ff + 1'b1;
              end
            end else begin
              nxt_byteIdx = byteIdx_ff + 1'b1;
            end
          end else begin
            nxt_state   = LWED_SYNC;
            nxt_syncCnt = restartRun(rxByte);
          end
        end
        LWED_HIT: nxt_state = LWED_HIT;
        default: nxt_state = LWED_SYNC;
      endcase
    end
  end

  // Matcher registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= LWED_SYNC;
      syncCnt_ff <= '0;
      byteIdx_ff <= '0;
      copyIdx_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      syncCnt_ff <= nxt_syncCnt;
      byteIdx_ff <= nxt_byteIdx;
      copyIdx_ff <= nxt_copyIdx;
    end
  end

  assign matched = (state_ff == LWED_HIT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hit_needs_copies: assert property ($rose(matched) |->
    $past(copyIdx_ff) == CW'(NCOPY - 1) && $past(byteIdx_ff) == BW'(NBYTES - 1))
    else $error("hit without full address copies");
  a_restart_on_break: assert property (
    (enable && byteValid && !frameStart && state_ff == LWED_ADDR &&
     rxByte != addrByte(nodeAddr, byteIdx_ff)) |=> state_ff == LWED_SYNC)
    else $error("broken copy did not restart search");
endmodule // lwed_magic_match
`default_nettype wire

/* File: hw/lwed_pkg.sv */
/*
  Shared constants of the wake event detector: configuration offsets,
  field positions, power state codes and magic packet figures.
  Assumes a dword-aligned configuration access port.
*/
`default_nettype none
package lwed_pkg;
  // ----------------------------------------------------------------
  // Configuration access
  // ----------------------------------------------------------------
  localparam int            CFG_AW         = 8;
  localparam int            CFG_DW         = 32;
  localparam int            CFG_BEW        = 4;
  localparam logic [7:0]    OFS_CMD_STATUS = 8'h04;
  localparam logic [7:0]    OFS_PMCSR      = 8'h44;
  localparam logic [7:0]    OFS_WAKE       = 8'h48;
  localparam logic [31:0]   RD_ZERO        = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS_CAP_BIT      = 20;
  localparam int PM_EN_BIT       = 8;
  localparam int PM_STS_BIT      = 15;
  localparam int WK_MAGIC_EN_BIT = 0;
  localparam int WK_FRAME_EN_BIT = 2;
  localparam int WK_MAGIC_SEEN   = 4;
  localparam int WK_FRAME_SEEN   = 5;
  localparam int WK_REMOTE_WAKE_FROM_LAN_BIT     = 30;
  localparam int WK_PM_CAPABILITY_SUPPORT_BIT    = 31;
  localparam int EE_PM_CAPABILITY_SUPPORT_BIT    = 15;
  localparam int EE_REMOTE_WAKE_FROM_LAN_BIT     = 14;
  localparam int BE_PS           = 0;
  localparam int BE_PM_HI        = 1;
  localparam int BE_WK_LO        = 0;
  localparam int PS_LSB          = 0;
  localparam int PS_MSB          = 1;
  // ----------------------------------------------------------------
  // Power states, flags, magic packet
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_D0      = 2'h0;
  localparam logic [1:0] PS_D3      = 2'h3;
  localparam int         FLAG_PME   = 0;
  localparam int         FLAG_MAGIC = 1;
  localparam int         FLAG_FRAME = 2;
  localparam int         FLAG_N     = 3;
  localparam int         SYNC_LEN   = 6;
  localparam int         ADDR_COPY  = 16;
  localparam int         ADDR_BYTES = 6;
  localparam logic [7:0] SYNC_BYTE  = 8'hFF;
endpackage
`default_nettype wire

/* File: hw/lwed_sticky_flags.sv */
/*
  Bank of sticky event flags: hardware sets, software clears.
  Assumes set and clear are one-cycle pulses on the same clock.
*/
`default_nettype none
module lwed_sticky_flags #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Set and clear pulses
  input  wire logic [WIDTH-1:0] setPulse,
  input  wire logic [WIDTH-1:0] clrPulse,
  // Flag state
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_ff;

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~clrPulse) | setPulse;
    end
  end

  assign flags = flags_ff;
endmodule // lwed_sticky_flags
`default_nettype wire

/* File: hw/lwed_wake_detector.sv */
/*
  Wake event detector top: configuration-space power management bits,
  serial EEPROM defaults, magic packet and wake frame events, and the
  open-drain wake request pin.
  Assumes the MAC delivers received bytes on this clock with end-of-frame
  status, and that configuration cycles arrive as single-cycle strobes.
*/
`default_nettype none
module lwed_wake_detector
  import lwed_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Configuration access
  input  wire logic                        cfgWrEn,
  input  wire logic                        cfgRdEn,
  input  wire logic [lwed_pkg::CFG_AW-1:0]  cfgAddr,
  input  wire logic [lwed_pkg::CFG_BEW-1:0] cfgByteEn,
  input  wire logic [lwed_pkg::CFG_DW-1:0]  cfgWrData,
  output logic      [lwed_pkg::CFG_DW-1:0]  cfgRdData,
  output logic                             cfgRdValid,
  // EEPROM defaults
  input  wire logic                        eeLoadValid,
  input  wire logic [15:0]                 eeWord08,
  // Received frame stream
  input  wire logic                        rxValid,
  input  wire logic                        rxSof,
  input  wire logic [7:0]                  rxByte,
  input  wire logic                        rxEof,
  input  wire logic                        rxCrcOk,
  input  wire logic                        rxAddrPass,
  input  wire logic [8*lwed_pkg::ADDR_BYTES-1:0] stationAddr,
  // Wake request pin, open drain
  output logic                             wakeRequestOutN,
  output logic                             wakeRequestOeN,
  // Low-power inhibits
  output logic                             busMasterInhibit,
  output logic                             txInhibit
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0]        pwrState_ff;
  logic              pmeEn_ff;
  logic              magicEn_ff;
  logic              frameEn_ff;
  logic              capPresent_ff;
  logic              pm_capability_support_ff;
  logic              remote_wake_from_lan_ff;
  logic              rwMode_ff;
  logic [CFG_DW-1:0] cfgRdData_ff;
  logic              cfgRdValid_ff;
  logic [FLAG_N-1:0] flagSet;
  logic [FLAG_N-1:0] flagClr;
  logic [FLAG_N-1:0] flags;
  logic              magicMatched;
  logic              wrPm;
  logic              wrWake;
  logic              d3ToD0;
  logic              eeRemote;
  logic              frameGood;
  logic              magicEvent;
  logic              frameEvent;
  logic              wakeEvent;
  logic              wakeAssert;
  logic [15:0]       pmcsrView;
  logic [31:0]       wakeView;
  logic [31:0]       csView;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Register write strobes and the power state transition
  assign wrPm   = cfgWrEn && cfgAddr == OFS_PMCSR;
  assign wrWake = cfgWrEn && cfgAddr == OFS_WAKE;
  assign d3ToD0 = wrPm && cfgByteEn[BE_PS] && pwrState_ff == PS_D3 &&
                  cfgWrData[PS_MSB:PS_LSB] == PS_D0;
  assign eeRemote = eeWord08[EE_PM_CAPABILITY_SUPPORT_BIT] && eeWord08[EE_REMOTE_WAKE_FROM_LAN_BIT];

  // ----------------------------------------------------------------
  // Power state and enables
  // ----------------------------------------------------------------
  // Power state field, written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrState_ff <= PS_D0;
    end else if (wrPm && cfgByteEn[BE_PS]) begin
      pwrState_ff <= cfgWrData[PS_MSB:PS_LSB];
    end
  end

  // wake output enable; leaves its timing to software
  always_ff @(posedge clk) begin
    if (rst) begin
      pmeEn_ff <= 1'b0;
    end else if (eeLoadValid) begin
      pmeEn_ff <= eeRemote;
    end else if (wrPm && cfgByteEn[BE_PM_HI] && pm_capability_support_ff) begin
      pmeEn_ff <= cfgWrData[PM_EN_BIT];
    end
  end

  // magic enable set by the remote wake condition
  always_ff @(posedge clk) begin
    if (rst) begin
      magicEn_ff <= 1'b0;
    end else if (eeLoadValid) begin
      magicEn_ff <= eeRemote;
    // D3 hot to D0 clears it
    end else if (d3ToD0) begin
      magicEn_ff <= 1'b0;
    end else if (wrWake && cfgByteEn[BE_WK_LO] && pm_capability_support_ff) begin
      magicEn_ff <= cfgWrData[WK_MAGIC_EN_BIT];
    end
  end

  // Wake frame enable, cleared by any hard-reset load
  always_ff @(posedge clk) begin
    if (rst) begin
      frameEn_ff <= 1'b0;
    end else if (eeLoadValid) begin
      frameEn_ff <= 1'b0;
    end else if (wrWake && cfgByteEn[BE_WK_LO] && pm_capability_support_ff) begin
      frameEn_ff <= cfgWrData[WK_FRAME_EN_BIT];
    end
  end

  // capability bits from EEPROM; remote wake bit too
  always_ff @(posedge clk) begin
    if (rst) begin
      capPresent_ff <= 1'b0;
      pm_capability_support_ff      <= 1'b0;
      remote_wake_from_lan_ff       <= 1'b0;
    end else if (eeLoadValid) begin
      capPresent_ff <= eeWord08[EE_PM_CAPABILITY_SUPPORT_BIT];
      pm_capability_support_ff      <= eeWord08[EE_PM_CAPABILITY_SUPPORT_BIT];
      remote_wake_from_lan_ff       <= eeWord08[EE_REMOTE_WAKE_FROM_LAN_BIT];
    end
  end

  // remote wake mode, left on D3 to D0 or when magic is disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      rwMode_ff <= 1'b0;
    end else if (eeLoadValid) begin
      rwMode_ff <= eeRemote;
    // Turning magic off by software also ends low-power mode, even if refused
    end else if (d3ToD0 || (wrWake && cfgByteEn[BE_WK_LO] && !cfgWrData[WK_MAGIC_EN_BIT])) begin
      rwMode_ff <= 1'b0;
    end
  end

  // no mastering or transmit in low-power remote wake
  assign busMasterInhibit = rwMode_ff;
  assign txInhibit        = rwMode_ff;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  // matcher runs only while enabled
  lwed_magic_match #(
    .NBYTES (ADDR_BYTES),
    .NSYNC  (SYNC_LEN),
    .NCOPY  (ADDR_COPY)
  ) u_match (
    .clk        (clk),
    .rst        (rst),
    .enable     (magicEn_ff),
    .byteValid  (rxValid),
    .frameStart (rxSof),
    .rxByte     (rxByte),
    .nodeAddr   (stationAddr),
    .matched    (magicMatched)
  );

  // filter pass; good CRC; judged at frame end
  assign frameGood  = rxEof && rxCrcOk && rxAddrPass;
  // each source gated by its own enable
  assign magicEvent = frameGood && magicEn_ff && magicMatched;
  assign frameEvent = frameGood && frameEn_ff;
  assign wakeEvent  = magicEvent || frameEvent;

  // status and event records; status set on any event
  assign flagSet[FLAG_PME]   = wakeEvent;
  assign flagSet[FLAG_MAGIC] = magicEvent;
  assign flagSet[FLAG_FRAME] = frameEvent;
  // write one to clear; the D3 to D0 change leaves them alone
  assign flagClr[FLAG_PME]   = wrPm && cfgByteEn[BE_PM_HI] && cfgWrData[PM_STS_BIT];
  assign flagClr[FLAG_MAGIC] = wrWake && cfgByteEn[BE_WK_LO] && cfgWrData[WK_MAGIC_SEEN];
  assign flagClr[FLAG_FRAME] = wrWake && cfgByteEn[BE_WK_LO] && cfgWrData[WK_FRAME_SEEN];

  lwed_sticky_flags #(
    .WIDTH (FLAG_N)
  ) u_flags (
    .clk      (clk),
    .rst      (rst),
    .setPulse (flagSet),
    .clrPulse (flagClr),
    .flags    (flags)
  );

  // ----------------------------------------------------------------
  // Wake pin
  // ----------------------------------------------------------------
  // enable and status both needed; combinational so a clear acts at once
  assign wakeAssert      = pmeEn_ff && flags[FLAG_PME];
  // Open drain: only ever pulls low
  assign wakeRequestOutN = 1'b0;
  assign wakeRequestOeN  = !wakeAssert;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Register views; unlisted bits read zero
  always_comb begin
    pmcsrView             = '0;
    pmcsrView[PS_MSB:PS_LSB] = pwrState_ff;
    pmcsrView[PM_EN_BIT]  = pmeEn_ff;
    pmcsrView[PM_STS_BIT] = flags[FLAG_PME];
    wakeView                  = '0;
    wakeView[WK_MAGIC_EN_BIT] = magicEn_ff;
    wakeView[WK_FRAME_EN_BIT] = frameEn_ff;
    wakeView[WK_MAGIC_SEEN]   = flags[FLAG_MAGIC];
    wakeView[WK_FRAME_SEEN]   = flags[FLAG_FRAME];
    wakeView[WK_REMOTE_WAKE_FROM_LAN_BIT]     = remote_wake_from_lan_ff;
    wakeView[WK_PM_CAPABILITY_SUPPORT_BIT]    = pm_capability_support_ff;
    csView             = '0;
    csView[CS_CAP_BIT] = capPresent_ff;
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgRdData_ff  <= RD_ZERO;
      cfgRdValid_ff <= 1'b0;
    end else begin
      cfgRdValid_ff <= cfgRdEn;
      if (cfgRdEn) begin
        case (cfgAddr)
          OFS_CMD_STATUS: cfgRdData_ff <= csView;
          OFS_PMCSR:      cfgRdData_ff <= {16'h0000, pmcsrView};
          OFS_WAKE:       cfgRdData_ff <= wakeView;
          default:        cfgRdData_ff <= RD_ZERO;
        endcase
      end
    end
  end

  assign cfgRdData  = cfgRdData_ff;
  assign cfgRdValid = cfgRdValid_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rw_load;
    eeLoadValid && eeRemote;
  endsequence

  sequence s_d3_exit_held;
    d3ToD0 && !cfgByteEn[BE_PM_HI] && !eeLoadValid && wakeAssert;
  endsequence

  a_wake_needs_enable: assert property (!wakeRequestOeN |-> pmeEn_ff)
    else $error("wake pin without enable");
  a_enable_clear_drops: assert property (
    (wrPm && cfgByteEn[BE_PM_HI] && !cfgWrData[PM_EN_BIT] && !eeLoadValid)
    |=> wakeRequestOeN)
    else $error("wake pin held after enable cleared");
  a_event_sets_status: assert property (wakeEvent |=> flags[FLAG_PME])
    else $error("wake event lost");
  a_status_clear_drops: assert property (
    (flagClr[FLAG_PME] && !wakeEvent) |=> wakeRequestOeN && !flags[FLAG_PME])
    else $error("wake pin held after status cleared");
  a_magic_gated: assert property ($rose(flags[FLAG_MAGIC]) |-> $past(magicEn_ff))
    else $error("magic event while disabled");
  a_cap_from_eeprom: assert property (
    eeLoadValid |=> capPresent_ff == $past(eeWord08[EE_PM_CAPABILITY_SUPPORT_BIT]))
    else $error("capability bit not loaded");
  a_remote_wake_from_lan_from_eeprom: assert property (
    eeLoadValid |=> remote_wake_from_lan_ff == $past(eeWord08[EE_REMOTE_WAKE_FROM_LAN_BIT]))
    else $error("remote wake bit not loaded");
  a_rw_mode_entry: assert property (
    s_rw_load |=> rwMode_ff && magicEn_ff && pmeEn_ff)
    else $error("remote wake mode not entered");
  a_magic_wakes: assert property (
    (magicEvent && rwMode_ff && pmeEn_ff && !cfgWrEn && !eeLoadValid) |=> !wakeRequestOeN)
    else $error("magic packet did not wake");
  a_d3_exit_keeps: assert property (s_d3_exit_held |=> !wakeRequestOeN)
    else $error("wake dropped on D3 exit");
  a_d3_exit_magic: assert property ((d3ToD0 && !eeLoadValid) |=> !magicEn_ff)
    else $error("magic enable kept on D3 exit");
  a_low_power_quiet: assert property (
    s_rw_load |=> busMasterInhibit && txInhibit)
    else $error("low power mode not quiet");
  a_magic_good_frame: assert property (
    $rose(flags[FLAG_MAGIC]) |-> $past(rxAddrPass && rxEof))
    else $error("magic without address pass");
  a_magic_crc_ok: assert property ($rose(flags[FLAG_MAGIC]) |-> $past(rxCrcOk))
    else $error("magic with CRC error");
  a_magic_records: assert property (
    magicEvent |=> flags[FLAG_MAGIC] && flags[FLAG_PME])
    else $error("magic match not recorded");
  a_frame_event: assert property (
    (frameGood && frameEn_ff) |=> flags[FLAG_FRAME] && flags[FLAG_PME])
    else $error("wake frame not recorded");
  a_frame_gated: assert property (
    $rose(flags[FLAG_FRAME]) |-> $past(frameEn_ff))
    else $error("frame event while disabled");
  a_rw_mode_exit: assert property (
    (d3ToD0 && !eeLoadValid) |=> !busMasterInhibit && !txInhibit)
    else $error("low power mode kept on D3 exit");
  a_no_cap_no_wake: assert property (
    !pm_capability_support_ff |-> !pmeEn_ff && !magicEn_ff && !frameEn_ff)
    else $error("enable set without capability");
endmodule // lwed_wake_detector
`default_nettype wire

/* File: verification/lwed_wake_detector_test.sv */
/*
  Self-checking bench for the wake event detector: config reads and
  writes, EEPROM load, frame stream and the resolved wake line.
  Assumes the pin model above and single-cycle config strobes.
*/
`default_nettype none
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin numErrors++; \
  $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module lwed_wake_detector_test import lwed_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, cfgWrEn = 0, cfgRdEn = 0, eeLoadValid = 0;
  logic [7:0]  cfgAddr = 0, rxByte = 0;
  logic [3:0]  cfgByteEn = 0;
  logic [31:0] cfgWrData = 0, cfgRdData;
  logic [15:0] eeWord08 = 0;
  logic        rxValid = 0, rxSof = 0, rxEof = 0, rxCrcOk = 0, rxAddrPass = 0;
  logic [47:0] stationAddr = 48'h6655_4433_2211;
  logic        cfgRdValid, wakeRequestOutN, wakeRequestOeN, busMasterInhibit, txInhibit;
  logic        wakeLine;
  int          numErrors = 0, samplesChecked = 0;
  // ----------------------------------------------------------------
  // Design, pin model and clock
  // ----------------------------------------------------------------
  lwed_wake_detector dut_u (.clk(clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .eeLoadValid(eeLoadValid), .eeWord08(eeWord08),
    .rxValid(rxValid), .rxSof(rxSof), .rxByte(rxByte), .rxEof(rxEof), .rxCrcOk(rxCrcOk),
    .rxAddrPass(rxAddrPass), .stationAddr(stationAddr), .wakeRequestOutN(wakeRequestOutN),
    .wakeRequestOeN(wakeRequestOeN), .busMasterInhibit(busMasterInhibit),
    .txInhibit(txInhibit));
  lwed_wake_line wake_u (.oeN(wakeRequestOeN), .outN(wakeRequestOutN), .wakeLine(wakeLine));
  initial begin
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic testDone();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfgWrEn <= 1; cfgAddr <= a; cfgByteEn <= be; cfgWrData <= d;
    @(posedge clk);
    cfgWrEn <= 0;
  endtask
  // Read answer is registered, so look just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk);
    cfgRdEn <= 1; cfgAddr <= a;
    @(posedge clk);
    cfgRdEn <= 0;
    #1;
    `CHK("read valid", 1'b1, cfgRdValid)
    `CHK(nm, ex, cfgRdData)
  endtask
  task automatic eeLoad(input logic [15:0] w);
    @(posedge clk);
    eeLoadValid <= 1;
    eeWord08 <= w;
    @(posedge clk);
    eeLoadValid <= 0;
  endtask
  task automatic putByte(input logic [7:0] b, input logic sof);
    @(posedge clk);
    rxValid <= 1; rxSof <= sof; rxByte <= b;
  endtask
  // Broken sync run and broken address copy up front: the search must restart
  task automatic frame(input bit magic, input logic crc, input logic pass);
    putByte(SYNC_BYTE, 1); putByte(SYNC_BYTE, 0); putByte(8'h00, 0);
    repeat (SYNC_LEN) putByte(SYNC_BYTE, 0);
    putByte(stationAddr[7:0], 0);
    putByte(8'h00, 0);
    if (magic) begin
      repeat (SYNC_LEN) putByte(SYNC_BYTE, 0);
      for (int c = 0; c < ADDR_COPY; c++)
        for (int i = 0; i < ADDR_BYTES; i++) putByte(stationAddr[8*i+:8], 0);
    end
    @(posedge clk);
    rxValid <= 0; rxSof <= 0; rxEof <= 1; rxCrcOk <= crc; rxAddrPass <= pass;
    @(posedge clk);
    rxEof <= 0;
    #1;
  endtask
  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    testDone();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    rd(OFS_WAKE, 32'h0000_0000, "wake reg reset");
    `CHK("idle line", 1'b1, wakeLine)
    eeLoad(16'hC000);
    rd(OFS_CMD_STATUS, 32'h0010_0000, "cap present");
    rd(OFS_WAKE, 32'hC000_0001, "wake reg load");
    `CHK("bus inhibit", 1'b1, busMasterInhibit)
    `CHK("tx inhibit", 1'b1, txInhibit)
    wr(OFS_PMCSR, 4'h1, 32'h3);
    frame(1, 0, 1);
    `CHK("crc bad line", 1'b1, wakeLine)
    frame(1, 1, 0);
    `CHK("filter fail line", 1'b1, wakeLine)
    frame(1, 1, 1);
    `CHK("magic line", 1'b0, wakeLine)
    rd(OFS_PMCSR, 32'h0000_8103, "pm status set");
    rd(OFS_WAKE, 32'hC000_0011, "magic seen");
    wr(OFS_PMCSR, 4'h1, 32'h0);
    #1;
    `CHK("line over d0", 1'b0, wakeLine)
    `CHK("inhibit off", 1'b0, txInhibit)
    rd(OFS_WAKE, 32'hC000_0010, "magic en cleared");
    wr(OFS_PMCSR, 4'h3, 32'h0000_8103);
    #1;
    `CHK("status clear line", 1'b1, wakeLine)
    frame(1, 1, 1);
    `CHK("magic off line", 1'b1, wakeLine)
    wr(OFS_WAKE, 4'h1, 32'h0000_0004);
    frame(0, 1, 1);
    `CHK("frame line", 1'b0, wakeLine)
    rd(OFS_WAKE, 32'hC000_0034, "frame seen");
    wr(OFS_PMCSR, 4'h2, 32'h0);
    #1;
    `CHK("enable clear line", 1'b1, wakeLine)
    frame(0, 1, 1);
    `CHK("disabled line", 1'b1, wakeLine)
    rd(OFS_PMCSR, 32'h0000_8003, "status kept");
    rd(8'h50, RD_ZERO, "unmapped");
    // Reset in mid-run, then loads without the remote wake combination
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(OFS_PMCSR, RD_ZERO, "pm after reset");
    `CHK("reset line", 1'b1, wakeLine)
    eeLoad(16'h8000);
    rd(OFS_WAKE, 32'h8000_0000, "no remote wake");
    `CHK("no inhibit", 1'b0, busMasterInhibit)
    eeLoad(16'h0000);
    wr(OFS_PMCSR, 4'h3, 32'h0000_0103);
    rd(OFS_PMCSR, 32'h0000_0003, "enable refused");
    testDone();
  end
endmodule // lwed_wake_detector_test
`default_nettype wire

/* File: verification/lwed_wake_line.sv */
/*
  Wake line seen by the system wake hardware: open-drain pin with pull-up.
  Assumes the detector drives pin data and an active-low output enable.
*/
`default_nettype none
module lwed_wake_line (
  // Pin drive from the detector
  input  wire logic oeN,
  input  wire logic outN,
  // Resolved board level
  output logic      wakeLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up wins whenever nobody drives, so a stale data value never shows
  assign wakeLine = oeN ? 1'b1 : outN;
endmodule // lwed_wake_line
`default_nettype wire
